// File: elic_pkg.sv
/*
 * constants, register map and source table of the eight-level interrupt controller.
 * assumes a 32-bit classic wishbone register bus and a core that runs on the same clock.
 */
package elic_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_LEVELS = 8;
    localparam int NUM_SRC = 17;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] ADR_MASK = 8'h00;
    localparam logic [7:0] ADR_PRIO = 8'h04;
    localparam logic [7:0] ADR_REQ = 8'h08;
    localparam logic [7:0] ADR_SYSMODE = 8'h0C;
    localparam logic [7:0] ADR_PEND = 8'h10;
    localparam logic [7:0] ADR_CTRL = 8'h14;
    localparam logic [7:0] ADR_STAT = 8'h18;

    // system mode fields
    localparam int MODE_GIE = 0;
    localparam int MODE_FAST_EN = 1;
    localparam int MODE_FLVL_LO = 2;
    localparam int MODE_FLVL_HI = 4;

    // control register: write-one strobes acting like the enable/disable instructions
    localparam int CTRL_EN = 0;
    localparam int CTRL_DIS = 1;

    // priority register fields
    localparam int PRI_A_SWAP = 0;
    localparam int PRI_GRP_LO = 1;
    localparam int PRI_B_GRP = 2;
    localparam int PRI_B_SUB = 3;
    localparam int PRI_GRP_MID = 4;
    localparam int PRI_C_GRP = 5;
    localparam int PRI_C_SUB = 6;
    localparam int PRI_GRP_HI = 7;

    // group identifiers and first level of each group
    localparam logic [1:0] GRP_A = 2'h0;
    localparam logic [1:0] GRP_B = 2'h1;
    localparam logic [1:0] GRP_C = 2'h2;
    localparam logic [2:0] BASE_A = 3'h0;
    localparam logic [2:0] BASE_B = 3'h2;
    localparam logic [2:0] BASE_C = 3'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and vector page
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [2:0] FLVL_RST = 3'h0;
    localparam logic [15:0] RESET_PC = 16'h0100;
    localparam logic [7:0] VEC_PAGE = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // source table, index order is ascending vector order
    // 0 timer a ovf, 1 timer a match, 2-5 comparators, 6 timer d ovf, 7 timer d match,
    // 8 timer c match, 9 pwm ovf, 10-15 port pins, 16 adc
    localparam logic [2:0] SRC_LEVEL [NUM_SRC] = '{
        3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2,
        3'h3, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h6};
    localparam logic [7:0] SRC_VECTOR [NUM_SRC] = '{
        8'hB0, 8'hB2, 8'hB4, 8'hB6, 8'hB8, 8'hBA, 8'hBC, 8'hBE, 8'hC0,
        8'hC2, 8'hC4, 8'hC6, 8'hC8, 8'hCA, 8'hCC, 8'hCE, 8'hD0};
    // pending bits that hardware clears when service starts
    localparam logic [NUM_SRC-1:0] AUTO_CLEAR = 17'h00241;

    ////////////////////////////////////////////////////////////////////////////////
    // service sequencer
    typedef enum logic [2:0] {
        ST_RESET,
        ST_IDLE,
        ST_PUSH_PCL,
        ST_PUSH_PCH,
        ST_PUSH_FLG,
        ST_FETCH_HI,
        ST_FETCH_LO,
        ST_LOAD
    } elic_state_e;

endpackage : elic_pkg

// File: elic_prio_resolve.sv
/*
 * level priority resolver: picks the winning level among the eligible ones.
 * assumes req_i already holds only pending, unmasked levels; purely combinational.
 */
`timescale 1ns/1ps

module elic_prio_resolve
    import elic_pkg::*;
(
    // eligible levels and priority setting
    input wire logic [7:0] req_i,
    input wire logic [7:0] prio_i,
    // winner
    output logic valid_o,
    output logic [2:0] level_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // group winner: first level against a two-level subgroup
    function automatic logic [3:0] pick3(input logic [2:0] r, input logic g, input logic s,
                                         input logic [2:0] base);
        logic [3:0] sub;
        logic [3:0] res;
        sub = 4'h0;
        res = 4'h0;
        if (s) begin
            sub = r[2] ? {1'b1, 3'(base + 3'h2)} : (r[1] ? {1'b1, 3'(base + 3'h1)} : 4'h0);
        end else begin
            sub = r[1] ? {1'b1, 3'(base + 3'h1)} : (r[2] ? {1'b1, 3'(base + 3'h2)} : 4'h0);
        end
        if (!g) begin
            res = r[0] ? {1'b1, base} : sub;
        end else begin
            res = sub[3] ? sub : (r[0] ? {1'b1, base} : 4'h0);
        end
        return res;
    endfunction : pick3

    // group order as {first, second, third}
    function automatic logic [5:0] group_order(input logic [2:0] sel);
        logic [5:0] ord;
        case (sel)
            3'h1: ord = {GRP_B, GRP_C, GRP_A};
            3'h2: ord = {GRP_A, GRP_B, GRP_C};
            3'h3: ord = {GRP_B, GRP_A, GRP_C};
            3'h4: ord = {GRP_C, GRP_A, GRP_B};
            3'h5: ord = {GRP_C, GRP_B, GRP_A};
            3'h6: ord = {GRP_A, GRP_C, GRP_B};
            default: ord = {GRP_A, GRP_B, GRP_C};
        endcase
        return ord;
    endfunction : group_order

    logic [3:0] grp_win [4];
    logic [5:0] ord;

    ////////////////////////////////////////////////////////////////////////////////
    // level number carries no weight, only the priority setting does
    always_comb begin
        grp_win[GRP_A] = pick3({1'b0, req_i[1:0]}, prio_i[PRI_A_SWAP], 1'b0, BASE_A);
        grp_win[GRP_B] = pick3(req_i[4:2], prio_i[PRI_B_GRP], prio_i[PRI_B_SUB], BASE_B);
        grp_win[GRP_C] = pick3(req_i[7:5], prio_i[PRI_C_GRP], prio_i[PRI_C_SUB], BASE_C);
        grp_win[3] = 4'h0;
        ord = group_order({prio_i[PRI_GRP_HI], prio_i[PRI_GRP_MID], prio_i[PRI_GRP_LO]});
        valid_o = 1'b0;
        level_o = 3'h0;
        // walk from lowest to highest ranked group, the last hit wins
        for (int p = 0; p < 3; p++) begin
            if (grp_win[ord[2*p +: 2]][3]) begin
                valid_o = 1'b1;
                level_o = grp_win[ord[2*p +: 2]][2:0];
            end
        end
    end

endmodule : elic_prio_resolve

// File: elic_top.sv
/*
 * eight-level interrupt controller: level mask, priority, per-level request status,
 * global and fast enables, and the service entry sequence towards the core.
 * assumes a classic wishbone master, single-cycle source event pulses, a core that
 * holds pc_i and flags_i steady while serving, and program memory with one cycle
 * of read latency.
 */
`timescale 1ns/1ps

module elic_top
    import elic_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt sources
    input wire logic [NUM_SRC-1:0] src_event_i,
    // core side
    input wire logic global_enable_instr_i,
    input wire logic global_disable_instr_i,
    input wire logic cpu_ack_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] flags_i,
    output logic irq_o,
    output logic [2:0] irq_level_o,
    output logic irq_fast_o,
    output logic gie_o,
    // stack push port
    output logic stk_push_o,
    output logic [7:0] stk_data_o,
    // program memory read port
    output logic pmem_rd_o,
    output logic [15:0] pmem_addr_o,
    input wire logic [7:0] pmem_data_i,
    // program counter load
    output logic pc_load_o,
    output logic [15:0] pc_target_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] level_mask_reg;
    logic [7:0] level_priority_reg;
    logic fast_en;
    logic [2:0] fast_lvl;
    logic [NUM_SRC-1:0] pend;
    logic [4:0] irq_src;
    logic [7:0] vec;
    logic [7:0] tgt_hi;
    elic_state_e state;

    logic [7:0] next_level_mask_reg;
    logic [7:0] next_level_priority_reg;
    logic next_gie;
    logic next_fast_en;
    logic [2:0] next_fast_lvl;
    logic [NUM_SRC-1:0] next_pend;
    logic [31:0] next_dat;
    logic next_ack;
    logic next_irq;
    logic [2:0] next_irq_level;
    logic next_irq_fast;
    logic [4:0] next_irq_src;
    logic [7:0] next_vec;
    logic [7:0] next_tgt_hi;
    elic_state_e next_state;
    logic next_stk_push;
    logic [7:0] next_stk_data;
    logic next_pmem_rd;
    logic [15:0] next_pmem_addr;
    logic next_pc_load;
    logic [15:0] next_pc_target;

    logic [7:0] lvl_req;
    logic win_valid;
    logic [2:0] win_level;
    logic [4:0] win_src;
    logic req_cyc;
    logic wr_commit;
    logic grant;
    logic [23:0] byte_mask;

    // word decode shared by reads and writes
    function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////////
    // per-level request status: or of the pending sources on each level
    for (genvar l = 0; l < NUM_LEVELS; l++) begin : g_lvl
        logic [NUM_SRC-1:0] members;
        for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
            assign members[s] = (SRC_LEVEL[s] == 3'(l));
        end
        assign lvl_req[l] = |(pend & members);
    end

    elic_prio_resolve u_resolve (
        .req_i(lvl_req & level_mask_reg),
        .prio_i(level_priority_reg),
        .valid_o(win_valid),
        .level_o(win_level)
    );

    // lowest index on the winning level, which is also its lowest vector
    always_comb begin
        win_src = 5'h00;
        for (int s = NUM_SRC - 1; s >= 0; s--) begin
            if (pend[s] && SRC_LEVEL[s] == win_level) begin
                win_src = 5'(s);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: ack one cycle after the request, dropped the cycle after
    assign req_cyc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land on the edge where the master sees ack
    assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign byte_mask = {{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        next_ack = req_cyc;
        next_dat = 32'h0000_0000;
        if (req_cyc && !wb_we_i) begin
            if (addr_hit(wb_adr_i, ADR_MASK)) begin
                next_dat[7:0] = level_mask_reg;
            end else if (addr_hit(wb_adr_i, ADR_PRIO)) begin
                next_dat[7:0] = level_priority_reg;
            end else if (addr_hit(wb_adr_i, ADR_REQ)) begin
                next_dat[7:0] = lvl_req;
            end else if (addr_hit(wb_adr_i, ADR_SYSMODE)) begin
                next_dat[MODE_FLVL_HI:0] = {fast_lvl, fast_en, gie_o};
            end else if (addr_hit(wb_adr_i, ADR_PEND)) begin
                // hardware-cleared pendings are not visible to software
                next_dat[NUM_SRC-1:0] = pend & ~AUTO_CLEAR;
            end else if (addr_hit(wb_adr_i, ADR_STAT)) begin
                next_dat[6:0] = {irq_level_o, irq_fast_o, irq_o, 1'b0, state != ST_IDLE};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers and global enable
    assign grant = (state == ST_IDLE) && irq_o && cpu_ack_i;

    always_comb begin
        next_level_mask_reg = level_mask_reg;
        next_level_priority_reg = level_priority_reg;
        next_gie = gie_o;
        next_fast_en = fast_en;
        next_fast_lvl = fast_lvl;
        if (wr_commit && wb_sel_i[0]) begin
            if (addr_hit(wb_adr_i, ADR_MASK)) begin
                next_level_mask_reg = wb_dat_i[7:0];
            end
            if (addr_hit(wb_adr_i, ADR_PRIO)) begin
                next_level_priority_reg = wb_dat_i[7:0];
            end
            if (addr_hit(wb_adr_i, ADR_SYSMODE)) begin
                next_gie = wb_dat_i[MODE_GIE];
                next_fast_en = wb_dat_i[MODE_FAST_EN];
                next_fast_lvl = wb_dat_i[MODE_FLVL_HI:MODE_FLVL_LO];
            end
            if (addr_hit(wb_adr_i, ADR_CTRL) && wb_dat_i[CTRL_EN]) begin
                next_gie = 1'b1;
            end
            if (addr_hit(wb_adr_i, ADR_CTRL) && wb_dat_i[CTRL_DIS]) begin
                next_gie = 1'b0;
            end
        end
        if (global_enable_instr_i) begin
            next_gie = 1'b1;
        end
        if (global_disable_instr_i) begin
            next_gie = 1'b0;
        end
        // a grant must close the gate even against a simultaneous enable
        if (grant) begin
            next_gie = 1'b0;
        end
    end

    // mask, priority and fast level get a defined value although software must set them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_mask_reg <= MASK_RST;
            level_priority_reg <= PRIO_RST;
            gie_o <= 1'b0;
            fast_en <= 1'b0;
            fast_lvl <= FLVL_RST;
        end else if (ce_i) begin
            level_mask_reg <= next_level_mask_reg;
            level_priority_reg <= next_level_priority_reg;
            gie_o <= next_gie;
            fast_en <= next_fast_en;
            fast_lvl <= next_fast_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // source pending bits: a new event beats any clear in the same cycle
    always_comb begin
        next_pend = pend;
        if (wr_commit && addr_hit(wb_adr_i, ADR_PEND)) begin
            next_pend = next_pend & ~(wb_dat_i[NUM_SRC-1:0] & byte_mask[NUM_SRC-1:0]
                                      & ~AUTO_CLEAR);
        end
        if (grant && AUTO_CLEAR[irq_src]) begin
            next_pend[irq_src] = 1'b0;
        end
        next_pend = next_pend | src_event_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend <= '0;
        end else if (ce_i) begin
            pend <= next_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // service sequencer: push pc low, pc high, flags (nothing in fast service), then fetch the two vector bytes
    always_comb begin
        next_state = state;
        next_irq = 1'b0;
        next_irq_level = irq_level_o;
        next_irq_src = irq_src;
        next_irq_fast = irq_fast_o;
        next_vec = vec;
        next_tgt_hi = tgt_hi;
        next_stk_push = 1'b0;
        next_stk_data = stk_data_o;
        next_pmem_rd = 1'b0;
        next_pmem_addr = pmem_addr_o;
        next_pc_load = 1'b0;
        next_pc_target = pc_target_o;
        case (state)
            ST_RESET: begin
                next_pc_load = 1'b1;
                next_pc_target = RESET_PC;
                next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (grant) begin
                    next_vec = SRC_VECTOR[irq_src];
                    next_irq_fast = fast_en && (fast_lvl == irq_level_o);
                    // fast service keeps its context in the core, nothing to push
                    if (fast_en && (fast_lvl == irq_level_o)) begin
                        next_pmem_rd = 1'b1;
                        next_pmem_addr = {VEC_PAGE, SRC_VECTOR[irq_src]};
                        next_state = ST_FETCH_HI;
                    end else begin
                        next_stk_push = 1'b1;
                        next_stk_data = pc_i[7:0];
                        next_state = ST_PUSH_PCL;
                    end
                end else begin
                    next_irq = gie_o && win_valid;
                    next_irq_level = win_level;
                    next_irq_src = win_src;
                end
            end
            ST_PUSH_PCL: begin
                next_stk_push = 1'b1;
                next_stk_data = pc_i[15:8];
                next_state = ST_PUSH_PCH;
            end
            ST_PUSH_PCH: begin
                next_stk_push = 1'b1;
                next_stk_data = flags_i;
                next_state = ST_PUSH_FLG;
            end
            ST_PUSH_FLG: begin
                next_pmem_rd = 1'b1;
                next_pmem_addr = {VEC_PAGE, vec};
                next_state = ST_FETCH_HI;
            end
            ST_FETCH_HI: begin
                next_pmem_rd = 1'b1;
                next_pmem_addr = {VEC_PAGE, 8'(vec + 8'h01)};
                next_state = ST_FETCH_LO;
            end
            ST_FETCH_LO: begin
                next_tgt_hi = pmem_data_i;
                next_state = ST_LOAD;
            end
            ST_LOAD: begin
                next_pc_load = 1'b1;
                next_pc_target = {tgt_hi, pmem_data_i};
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_RESET;
            irq_o <= 1'b0;
            irq_level_o <= 3'h0;
            irq_src <= 5'h00;
            irq_fast_o <= 1'b0;
            vec <= 8'h00;
            tgt_hi <= 8'h00;
            stk_push_o <= 1'b0;
            stk_data_o <= 8'h00;
            pmem_rd_o <= 1'b0;
            pmem_addr_o <= 16'h0000;
            pc_load_o <= 1'b0;
            pc_target_o <= 16'h0000;
        end else if (ce_i) begin
            state <= next_state;
            irq_o <= next_irq;
            irq_level_o <= next_irq_level;
            irq_src <= next_irq_src;
            irq_fast_o <= next_irq_fast;
            vec <= next_vec;
            tgt_hi <= next_tgt_hi;
            stk_push_o <= next_stk_push;
            stk_data_o <= next_stk_data;
            pmem_rd_o <= next_pmem_rd;
            pmem_addr_o <= next_pmem_addr;
            pc_load_o <= next_pc_load;
            pc_target_o <= next_pc_target;
        end
    end

endmodule : elic_top

// File: elic_core_model.sv
/*
 * stand-in for the core and program memory beside the interrupt controller.
 * assumes one clock; the bench raises ack_en_i when a grant is wanted.
 */
`timescale 1ns/1ps

module elic_core_model (
    // clock and bench control
    input wire logic clk_i,
    input wire logic ack_en_i,
    // controller side
    input wire logic irq_i,
    input wire logic pmem_rd_i,
    input wire logic [15:0] pmem_addr_i,
    output logic cpu_ack_o,
    output logic [7:0] pmem_data_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle grant while a request stands; the memory answers one cycle after a read
    initial cpu_ack_o = 1'b0;
    initial pmem_data_o = 8'h00;
    always_ff @(posedge clk_i) begin
        cpu_ack_o <= ack_en_i && irq_i && !cpu_ack_o;
        // released bus toggles so a stale byte is never mistaken for data
        pmem_data_o <= pmem_rd_i ? (pmem_addr_i[7:0] ^ 8'hA5) : ~pmem_data_o;
    end
endmodule : elic_core_model

// File: elic_top_props.sv
/*
 * concurrent checks on the ports of the interrupt controller.
 * assumes ce_i held high and the bench's core model.
 */
`timescale 1ns/1ps

module elic_top_props (
    // watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic global_enable_instr_i,
    input wire logic global_disable_instr_i,
    input wire logic cpu_ack_i,
    input wire logic [15:0] pc_i,
    input wire logic irq_o,
    input wire logic gie_o,
    input wire logic stk_push_o,
    input wire logic [7:0] stk_data_o,
    input wire logic pmem_rd_o,
    input wire logic [15:0] pmem_addr_o,
    input wire logic [7:0] pmem_data_i,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_target_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_start: assert property ($fell(rst_i) |-> ##[0:2] (pc_load_o && pc_target_o == 16'h0100))
        else $error("reset start address wrong");
    a_grant_entry: assert property (cpu_ack_i && irq_o |=> (!gie_o && !irq_o) [*4])
        else $error("grant did not disable interrupts");
    a_push_first: assert property (cpu_ack_i && irq_o |=> (stk_push_o && stk_data_o == pc_i[7:0]) || pmem_rd_o)
        else $error("grant did not start with pc low push or fetch");
    a_vector_page: assert property (pmem_rd_o |-> pmem_addr_o[15:8] == 8'h00)
        else $error("vector fetch outside lowest page");
    a_fetch_pair: assert property (pmem_rd_o && !$past(pmem_rd_o) |=> pmem_rd_o && pmem_addr_o == $past(pmem_addr_o) + 16'h0001)
        else $error("second vector byte not from next address");
    a_target_join: assert property ((pmem_rd_o ##1 pmem_rd_o) |=> ##1 (pc_load_o && pc_target_o == {$past(pmem_data_i, 2), $past(pmem_data_i)}))
        else $error("service target not joined from vector bytes");
    a_irq_gated: assert property (irq_o |-> gie_o || $past(gie_o))
        else $error("request shown while globally disabled");
    a_gie_set: assert property (global_enable_instr_i && !global_disable_instr_i && !(cpu_ack_i && irq_o) |=> gie_o)
        else $error("enable instruction did not set global enable");
    a_gie_clear: assert property (global_disable_instr_i |=> !gie_o)
        else $error("disable instruction did not clear global enable");
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    // main scenarios seen
    c_grant: cover property (cpu_ack_i && irq_o);
    c_fetch: cover property (pmem_rd_o ##1 pmem_rd_o);
    c_enable: cover property (global_enable_instr_i ##[1:3] irq_o);
endmodule : elic_top_props

bind elic_top elic_top_props i_elic_top_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .global_enable_instr_i, .global_disable_instr_i, .cpu_ack_i, .pc_i, .irq_o, .gie_o, .stk_push_o,
    .stk_data_o, .pmem_rd_o, .pmem_addr_o, .pmem_data_i, .pc_load_o, .pc_target_o);

// File: elic_top_bench.sv
/*
 * self-checking bench for the interrupt controller, one task per scenario.
 * assumes the core model file and the checker bound alongside.
 */
`timescale 1ns/1ps

module elic_top_bench import elic_pkg::*;;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ena = 1'b0, dis = 1'b0;
    logic ack_en = 1'b0, fast_exp = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat;
    logic [NUM_SRC-1:0] src = '0;
    logic ack, irq, fast, gie, cpu_ack, rd, pl, push;
    logic [31:0] dout;
    logic [2:0] lvl;
    logic [15:0] paddr, tgt;
    logic [7:0] pdata, sdat;
    int n_mismatch = 0, samples_checked = 0;

    elic_top i_elic_top (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .src_event_i(src), .global_enable_instr_i(ena), .global_disable_instr_i(dis),
        .cpu_ack_i(cpu_ack), .pc_i(16'h1234), .flags_i(8'h5C), .irq_o(irq), .irq_level_o(lvl),
        .irq_fast_o(fast), .gie_o(gie), .stk_push_o(push), .stk_data_o(sdat), .pmem_rd_o(rd),
        .pmem_addr_o(paddr), .pmem_data_i(pdata), .pc_load_o(pl), .pc_target_o(tgt));
    elic_core_model i_elic_core_model (.clk_i, .ack_en_i(ack_en), .irq_i(irq), .pmem_rd_i(rd),
        .pmem_addr_i(paddr), .cpu_ack_o(cpu_ack), .pmem_data_o(pdata));

    ////////////////////////////////////////////////////////////////////////////////
    // shared steps
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; a missing ack counts against the run
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask : wb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd_chk
    task automatic ev(input logic [NUM_SRC-1:0] m);
        @(posedge clk_i) src <= m;
        @(posedge clk_i) src <= '0;
    endtask : ev
    task automatic instr(input logic e);
        @(posedge clk_i) begin
            ena <= e;
            dis <= !e;
        end
        @(posedge clk_i) begin
            ena <= 1'b0;
            dis <= 1'b0;
        end
    endtask : instr
    // enable, check the shown level, let the core grant, check pushes and the loaded target
    task automatic serve(input logic [2:0] l, input logic [7:0] v);
        int n;
        logic [23:0] stk;
        n = 0;
        stk = 24'h0;
        instr(1'b1);
        repeat (2) @(posedge clk_i);
        chk({28'h0, irq, lvl}, {28'h0, 1'b1, l});
        ack_en <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (push === 1'b1) stk = {stk[15:0], sdat};
        end while (pl !== 1'b1 && n < 20);
        chk({16'h0, tgt}, {16'h0, v ^ 8'hA5, (v + 8'h01) ^ 8'hA5});
        chk({7'h0, fast, stk}, fast_exp ? 32'h0100_0000 : 32'h0034_125C);
        ack_en <= 1'b0;
    endtask : serve

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs;
        rd_chk(ADR_REQ, 32'h0);
        rd_chk(ADR_SYSMODE, 32'h0);
        wb(1'b1, ADR_MASK, 32'hA5);
        rd_chk(ADR_MASK, 32'hA5);
        wb(1'b1, ADR_CTRL, 32'h1);
        rd_chk(ADR_SYSMODE, 32'h1);
        wb(1'b1, ADR_CTRL, 32'h2);
        rd_chk(ADR_STAT, 32'h0);
        rd_chk(ADR_SYSMODE, 32'h0);
        wb(1'b1, ADR_REQ, 32'hFF);
        rd_chk(ADR_REQ, 32'h0);
        rd_chk(8'h40, 32'h0);
    endtask : t_regs
    task automatic t_mask;
        instr(1'b0);
        wb(1'b1, ADR_MASK, 32'h0);
        ev(17'h00400);
        rd_chk(ADR_REQ, 32'h20);
        instr(1'b1);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        instr(1'b0);
        wb(1'b1, ADR_MASK, 32'h20);
        serve(3'h5, 8'hC4);
        rd_chk(ADR_REQ, 32'h20);
        wb(1'b1, ADR_PEND, 32'h400);
        rd_chk(ADR_REQ, 32'h0);
    endtask : t_mask
    task automatic t_prio;
        wb(1'b1, ADR_MASK, 32'hFF);
        wb(1'b1, ADR_PRIO, 32'h02);
        ev(17'h00882);
        serve(3'h2, 8'hBE);
        wb(1'b1, ADR_PRIO, 32'h82);
        serve(3'h5, 8'hC6);
        wb(1'b1, ADR_PEND, 32'h880);
        serve(3'h0, 8'hB2);
        wb(1'b1, ADR_PEND, 32'h1FFFF);
        ev(17'h0000C);
        serve(3'h1, 8'hB4);
        wb(1'b1, ADR_PEND, 32'h1FFFF);
    endtask : t_prio
    task automatic t_auto_fast;
        ev(17'h00001);
        serve(3'h0, 8'hB0);
        rd_chk(ADR_REQ, 32'h0);
        wb(1'b1, ADR_SYSMODE, 32'h1A);
        ev(17'h10000);
        fast_exp = 1'b1;
        serve(3'h6, 8'hD0);
        chk({31'h0, fast}, 32'h1);
    endtask : t_auto_fast

    ////////////////////////////////////////////////////////////////////////////////
    // verdict, clock, watchdog and main sequence
    task automatic wrap_up;
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial forever #10 clk_i = ~clk_i;
    // far above the few hundred cycles the scenarios need
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_mask();
        t_prio();
        t_auto_fast();
        wrap_up();
    end
endmodule : elic_top_bench
